/* File: pkg/timer_oc_pkg.sv */
// Register map, field layout, reset values and mode codes of the timer compare unit
package timer_oc_pkg;

  // Register addresses on the byte-wide register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL_A = 4'h0;
  localparam logic [3:0] REG_CTRL_B = 4'h1;
  localparam logic [3:0] REG_FORCE = 4'h2;
  localparam logic [3:0] REG_COUNT_LOW = 4'h3;
  localparam logic [3:0] REG_COUNT_HIGH = 4'h4;
  localparam logic [3:0] REG_CAPT_LOW = 4'h5;
  localparam logic [3:0] REG_CAPT_HIGH = 4'h6;
  localparam logic [3:0] REG_CMPA_LOW = 4'h7;
  localparam logic [3:0] REG_CMPA_HIGH = 4'h8;
  localparam logic [3:0] REG_CMPB_LOW = 4'h9;
  localparam logic [3:0] REG_CMPB_HIGH = 4'hA;
  localparam logic [3:0] REG_IRQ_EN = 4'hB;
  localparam logic [3:0] REG_FLAGS = 4'hC;

  // Field positions
  localparam int CTRL_A_ACT_A_POS = 6;
  localparam int CTRL_A_ACT_B_POS = 4;
  localparam int CTRL_A_MODE_LO_POS = 0;
  localparam int CTRL_B_MODE_HI_POS = 3;
  localparam int CTRL_B_RUN_POS = 0;
  localparam int FORCE_A_POS = 7;
  localparam int FORCE_B_POS = 6;
  localparam int FLAG_A_POS = 1;
  localparam int FLAG_B_POS = 2;
  localparam int FLAG_CAPT_POS = 5;

  // Reset values
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // Waveform mode codes with special meaning
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CLEAR_CMPA = 4'h4;
  localparam logic [3:0] MODE_CLEAR_CAPT = 4'hC;
  localparam logic [3:0] MODE_RESERVED = 4'hD;

  // Output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Timer clock divider default
  localparam int TICK_DIV_DEFAULT = 1;

endpackage

/* File: design/timer_output_compare_unit.sv */
// Timer compare unit: counter, capture register, two buffered compare channels
//
// Functional notes
// - New capture overwrites unread capture value
// - Each channel compares count with compare value
// - Match flag sets one timer tick later
// - Enabled flag requests interrupt, clears on service
// - Writing one clears flag, zero keeps it
// - Output follows match, mode, action, top, bottom
// - Channel A value may set counter top
// - Two channels, each with full own resources
// - Compare buffered in PWM modes only
// - Buffer transfers only at top or bottom
// - CPU reaches buffer or active register by mode
// - Compare high byte reads direct, not holding
// - High byte first; low write loads sixteen bits
// - Force updates output only, no flag, no counter
// - Counter write blocks matches next timer tick
// - Count written at variable top runs to FFFF
// - Output state survives waveform mode changes
// - Output action change takes effect immediately
// - Reset clears each output state to zero
// - Action zero leaves output unchanged on match
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module timer_output_compare_unit
  import timer_oc_pkg::*;
#(
  parameter int TICK_DIV = TICK_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RD_DATA,
  // Capture trigger, already edge detected
  input wire logic CAPTURE_EVENT,
  // Interrupt requests and service acknowledges
  output logic IRQ_A,
  output logic IRQ_B,
  output logic IRQ_CAPT,
  input wire logic IRQ_ACK_A,
  input wire logic IRQ_ACK_B,
  input wire logic IRQ_ACK_CAPT,
  // Compare outputs and their port override enables
  output logic COMPARE_OUT_A,
  output logic COMPARE_OUT_B,
  output logic COMPARE_OUT_EN_A,
  output logic COMPARE_OUT_EN_B
);

  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [7:0] irq_en;
  logic [7:0] temp;
  logic [15:0] timer_count;
  logic [15:0] capture_value;
  logic capture_flag;
  logic dir_down;
  logic block_pending;
  logic [15:0] div_cnt;
  logic [15:0] active [2];
  logic [15:0] buffer [2];
  logic [1:0] compare_match_flag;
  logic [1:0] oc;
  logic [1:0] action [2];
  logic [1:0] hit;
  logic [1:0] force_hit;
  logic [1:0] wr_cmp_low;
  logic [1:0] irq_ack;
  logic [7:0] rd_mux;

  // Register decode
  wire wr_ctrl_a = WR_STB && (ADDR == REG_CTRL_A);
  wire wr_ctrl_b = WR_STB && (ADDR == REG_CTRL_B);
  wire wr_force = WR_STB && (ADDR == REG_FORCE);
  wire wr_count_low = WR_STB && (ADDR == REG_COUNT_LOW);
  wire wr_capt_low = WR_STB && (ADDR == REG_CAPT_LOW);
  wire wr_irq_en = WR_STB && (ADDR == REG_IRQ_EN);
  wire wr_flags = WR_STB && (ADDR == REG_FLAGS);
  wire wr_high = WR_STB && ((ADDR == REG_COUNT_HIGH) || (ADDR == REG_CAPT_HIGH) ||
                            (ADDR == REG_CMPA_HIGH) || (ADDR == REG_CMPB_HIGH));
  wire rd_count_low = RD_STB && (ADDR == REG_COUNT_LOW);
  wire rd_capt_low = RD_STB && (ADDR == REG_CAPT_LOW);
  wire [15:0] wr_word = {temp, WR_DATA};

  // Mode decode
  wire [3:0] wgm = {ctrl_b[CTRL_B_MODE_HI_POS +: 2], ctrl_a[CTRL_A_MODE_LO_POS +: 2]};
  // buffering only in the twelve PWM modes
  wire is_pwm = !((wgm == MODE_NORMAL) || (wgm == MODE_CLEAR_CMPA) ||
                  (wgm == MODE_CLEAR_CAPT) || (wgm == MODE_RESERVED));
  wire dual_slope = (wgm == 4'h1) || (wgm == 4'h2) || (wgm == 4'h3) ||
                    ((wgm >= 4'h8) && (wgm <= 4'hB));
  wire upd_bottom = (wgm == 4'h8) || (wgm == 4'h9);
  wire capt_is_top = (wgm == 4'h8) || (wgm == 4'hA) || (wgm == MODE_CLEAR_CAPT) ||
                     (wgm == 4'hE);

  // channel A compare value as counter top
  wire cmpa_is_top = (wgm == MODE_CLEAR_CMPA) || (wgm == 4'h9) || (wgm == 4'hB) ||
                     (wgm == 4'hF);
  wire [15:0] top_value = cmpa_is_top ? active[0] :
                          capt_is_top ? capture_value :
                          ((wgm == 4'h1) || (wgm == 4'h5)) ? 16'h00FF :
                          ((wgm == 4'h2) || (wgm == 4'h6)) ? 16'h01FF :
                          ((wgm == 4'h3) || (wgm == 4'h7)) ? 16'h03FF : COUNT_MAX;

  // Timer clock as a one-cycle enable; stopped while the run bit is low
  wire run = ctrl_b[CTRL_B_RUN_POS];
  wire tick = run && (div_cnt == 16'h0000);

  // a blocked top match lets the counter run on to FFFF
  wire at_top = (timer_count == top_value) && !block_pending;
  wire at_bottom_turn = dual_slope && dir_down && (timer_count == 16'h0000);
  // transfer points at top or bottom only
  wire update_pt = tick && is_pwm && (upd_bottom ? at_bottom_turn : at_top);
  wire fast_wrap = tick && is_pwm && !dual_slope && at_top;

  assign irq_ack = {IRQ_ACK_B, IRQ_ACK_A};
  assign action[0] = ctrl_a[CTRL_A_ACT_A_POS +: 2];
  assign action[1] = ctrl_a[CTRL_A_ACT_B_POS +: 2];

  // Timer clock divider
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !run || (div_cnt == 16'(TICK_DIV - 1))) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // any counter write blocks matches at the next timer tick
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      block_pending <= 1'b0;
    end else if (wr_count_low) begin
      block_pending <= 1'b1;
    end else if (tick) begin
      block_pending <= 1'b0;
    end
  end

  // Counter; a CPU write has priority over counting
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      timer_count <= COUNT_RESET;
      dir_down <= 1'b0;
    end else if (wr_count_low) begin
      timer_count <= wr_word;
    end else if (tick) begin
      if (!dual_slope) begin
        dir_down <= 1'b0;
        timer_count <= at_top ? 16'h0000 : timer_count + 16'h0001;
      end else if (dir_down) begin
        if (timer_count == 16'h0000) begin
          dir_down <= 1'b0;
          timer_count <= 16'h0001;
        end else begin
          timer_count <= timer_count - 16'h0001;
        end
      end else if (at_top) begin
        dir_down <= 1'b1;
        timer_count <= timer_count - 16'h0001;
      end else begin
        timer_count <= timer_count + 16'h0001;
      end
    end
  end

  // shared holding byte: loaded by high writes and by count and capture low reads
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      temp <= 8'h00;
    end else if (wr_high) begin
      temp <= WR_DATA;
    end else if (rd_count_low) begin
      temp <= timer_count[15:8];
    end else if (rd_capt_low) begin
      temp <= capture_value[15:8];
    end
  end

  // capture overwrites whatever software has not read yet
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      capture_value <= COUNT_RESET;
    end else if (wr_capt_low && capt_is_top) begin
      capture_value <= wr_word;
    end else if (CAPTURE_EVENT && !capt_is_top) begin
      capture_value <= timer_count;
    end
  end

  // Capture flag; a new event wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      capture_flag <= 1'b0;
    end else if (CAPTURE_EVENT && !capt_is_top) begin
      capture_flag <= 1'b1;
    end else if ((wr_flags && WR_DATA[FLAG_CAPT_POS]) || IRQ_ACK_CAPT) begin
      capture_flag <= 1'b0;
    end
  end

  // control registers; action bits act at once, they are not buffered
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl_a <= CTRL_A_RESET;
      ctrl_b <= CTRL_B_RESET;
      irq_en <= IRQ_EN_RESET;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a <= WR_DATA & 8'hF3;
      end
      if (wr_ctrl_b) begin
        ctrl_b <= WR_DATA & 8'h19;
      end
      if (wr_irq_en) begin
        irq_en <= WR_DATA & 8'h26;
      end
    end
  end

  // one identical slice per compare channel
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic next_oc;

    assign wr_cmp_low[i] = WR_STB && (ADDR == ((i == 0) ? REG_CMPA_LOW : REG_CMPB_LOW));
    // sixteen-bit equality, gated by the tick and the write block
    assign hit[i] = tick && !block_pending && (timer_count == active[i]);
    // force acts only outside PWM modes
    assign force_hit[i] = wr_force && !is_pwm &&
                          WR_DATA[(i == 0) ? FORCE_A_POS : FORCE_B_POS];

    // low write lands in the buffer, and in the active word unbuffered
    always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
        buffer[i] <= COMPARE_RESET;
        active[i] <= COMPARE_RESET;
      end else begin
        if (wr_cmp_low[i]) begin
          buffer[i] <= wr_word;
        end
        if (wr_cmp_low[i] && !is_pwm) begin
          active[i] <= wr_word;
        end else if (update_pt) begin
          active[i] <= buffer[i];
        end
      end
    end

    // flag rises on the edge after the matching tick
    // a one written clears, a zero keeps; a new hit wins
    always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
        compare_match_flag[i] <= 1'b0;
      end else if (hit[i]) begin
        compare_match_flag[i] <= 1'b1;
      end else if ((wr_flags && WR_DATA[(i == 0) ? FLAG_A_POS : FLAG_B_POS]) || irq_ack[i]) begin
        compare_match_flag[i] <= 1'b0;
      end
    end

    // waveform decisions; the wrap update wins over an equal match
    always_comb begin
      next_oc = oc[i];
      if (!is_pwm) begin
        if (hit[i] || force_hit[i]) begin
          unique case (action[i])
            ACT_TOGGLE: next_oc = !oc[i];
            ACT_CLEAR: next_oc = 1'b0;
            ACT_SET: next_oc = 1'b1;
            ACT_NONE: next_oc = oc[i];
          endcase
        end
      end else if (fast_wrap && action[i][1]) begin
        next_oc = !action[i][0];
      end else if (hit[i] && action[i][1]) begin
        next_oc = action[i][0] ^ (dual_slope && dir_down);
      end
    end

    // output state cleared only by reset
    // mode changes never touch the held state
    always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
        oc[i] <= 1'b0;
      end else begin
        oc[i] <= next_oc;
      end
    end
  end

  // compare reads come straight from the register, never the holding byte
  assign rd_mux =
    (ADDR == REG_CTRL_A) ? ctrl_a :
    (ADDR == REG_CTRL_B) ? ctrl_b :
    (ADDR == REG_COUNT_LOW) ? timer_count[7:0] :
    (ADDR == REG_COUNT_HIGH) ? temp :
    (ADDR == REG_CAPT_LOW) ? capture_value[7:0] :
    (ADDR == REG_CAPT_HIGH) ? temp :
    (ADDR == REG_CMPA_LOW) ? (is_pwm ? buffer[0][7:0] : active[0][7:0]) :
    (ADDR == REG_CMPA_HIGH) ? (is_pwm ? buffer[0][15:8] : active[0][15:8]) :
    (ADDR == REG_CMPB_LOW) ? (is_pwm ? buffer[1][7:0] : active[1][7:0]) :
    (ADDR == REG_CMPB_HIGH) ? (is_pwm ? buffer[1][15:8] : active[1][15:8]) :
    (ADDR == REG_IRQ_EN) ? irq_en :
    (ADDR == REG_FLAGS) ? {2'h0, capture_flag, 2'h0, compare_match_flag, 1'b0} : 8'h00;

  // Read data stand only in the cycle after the strobe; force reads zero
  always_ff @(posedge CORE_CLK) begin
    if (RESET || !RD_STB) begin
      RD_DATA <= 8'h00;
    end else begin
      RD_DATA <= rd_mux;
    end
  end

  assign IRQ_A = compare_match_flag[0] && irq_en[FLAG_A_POS];
  assign IRQ_B = compare_match_flag[1] && irq_en[FLAG_B_POS];
  assign IRQ_CAPT = capture_flag && irq_en[FLAG_CAPT_POS];
  assign COMPARE_OUT_A = oc[0];
  assign COMPARE_OUT_B = oc[1];
  // Port override whenever an action is selected
  assign COMPARE_OUT_EN_A = (action[0] != ACT_NONE);
  assign COMPARE_OUT_EN_B = (action[1] != ACT_NONE);

  // Checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  property p_capture_overwrite;
    CAPTURE_EVENT && !capt_is_top |=> capture_value == $past(timer_count) && capture_flag;
  endproperty
  a_capture_overwrite: assert property (p_capture_overwrite) else $error("capture not taken");

  property p_flag_delay;
    hit[0] && !compare_match_flag[0] |-> !compare_match_flag[0] ##1 compare_match_flag[0];
  endproperty
  a_flag_delay: assert property (p_flag_delay) else $error("flag A timing wrong");

  property p_irq_service;
    IRQ_ACK_A && !hit[0] |=> !compare_match_flag[0] && !IRQ_A;
  endproperty
  a_irq_service: assert property (p_irq_service) else $error("flag A not cleared by service");

  property p_flag_w1c;
    wr_flags && !hit[1] && !IRQ_ACK_B |=>
      compare_match_flag[1] == ($past(compare_match_flag[1]) && !$past(WR_DATA[FLAG_B_POS]));
  endproperty
  a_flag_w1c: assert property (p_flag_w1c) else $error("flag B write effect wrong");

  property p_buffer_hold;
    is_pwm && !update_pt ##1 is_pwm |-> $stable(active[0]) && $stable(active[1]);
  endproperty
  a_buffer_hold: assert property (p_buffer_hold) else $error("compare changed mid period");

  property p_direct_write;
    wr_cmp_low[1] && !is_pwm |=> active[1] == {$past(temp), $past(WR_DATA)};
  endproperty
  a_direct_write: assert property (p_direct_write) else $error("direct compare write lost");

  property p_force_no_flag;
    force_hit[0] && !hit[0] |=> compare_match_flag[0] == $past(compare_match_flag[0]);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) else $error("force touched flag");

  property p_block;
    wr_count_low |=> block_pending && !hit[0] && !hit[1];
  endproperty
  a_block: assert property (p_block) else $error("match not blocked after count write");

  property p_action_none;
    action[0] == ACT_NONE && !is_pwm |=> $stable(oc[0]);
  endproperty
  a_action_none: assert property (p_action_none) else $error("output moved with no action");

  property p_reset_out;
    @(posedge CORE_CLK) disable iff (1'b0) RESET |=> !COMPARE_OUT_A && !COMPARE_OUT_B;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("output not cleared by reset");

  c_capture_twice: cover property (CAPTURE_EVENT ##[1:20] CAPTURE_EVENT);
  c_match_a: cover property (hit[0] && action[0] == ACT_TOGGLE);
  c_transfer: cover property (update_pt && buffer[0] != active[0]);

endmodule

`default_nettype wire

/* File: tb/cpu_port_model.sv */
// Processor-side model driving the register port and interrupt acknowledges
`timescale 1ns/10ps
`default_nettype none

module cpu_port_model
  import timer_oc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic [ADDR_W-1:0] addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic rd_stb,
  input wire logic [7:0] rd_data,
  // Interrupt acknowledges: bit 0 A, bit 1 B, bit 2 capture
  output logic [2:0] ack
);
  // Idle bus at time zero
  initial begin
    addr = 4'h0;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    ack = 3'h0;
  end

  // One write cycle; released lines show the inverse so stale values never look valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
  endtask

  // One read cycle; data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1;
    d = rd_data;
  endtask

  // callers write the count only while the timer is stopped
  task automatic wr16(input logic [ADDR_W-1:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask

  // One-cycle service acknowledge
  task automatic ack_pulse(input int idx);
    @(posedge clk);
    ack[idx] <= 1'b1;
    @(posedge clk);
    ack[idx] <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/timer_output_compare_unit_tb.sv */
// Self-checking bench of the timer compare unit against a small reference model
`timescale 1ns/10ps
`default_nettype none

module timer_output_compare_unit_tb
  import timer_oc_pkg::*;
;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic wr_stb;
  logic rd_stb;
  logic cap_ev;
  logic [2:0] ack;
  logic irq_a, irq_b, irq_c, out_a, out_b, en_a, en_b;
  int n_fail;
  int num_checks;
  logic [31:0] seed;
  logic [31:0] r;
  int cap_q[$];
  logic [15:0] v;
  logic [15:0] k;
  logic [15:0] got;
  logic [7:0] d;
  logic exp_out;
  logic [1:0] acts [5];

  timer_output_compare_unit #(.TICK_DIV(1)) i_dut (
    .CORE_CLK(clk), .RESET(rst), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RD_DATA(rd_data), .CAPTURE_EVENT(cap_ev),
    .IRQ_A(irq_a), .IRQ_B(irq_b), .IRQ_CAPT(irq_c),
    .IRQ_ACK_A(ack[0]), .IRQ_ACK_B(ack[1]), .IRQ_ACK_CAPT(ack[2]),
    .COMPARE_OUT_A(out_a), .COMPARE_OUT_B(out_b),
    .COMPARE_OUT_EN_A(en_a), .COMPARE_OUT_EN_B(en_b)
  );

  cpu_port_model i_cpu (
    .clk(clk), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .ack(ack)
  );

  // Clock at 40 MHz
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Fixed-seed xorshift keeps runs repeatable
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chkb(input string name, input logic e, input logic g);
    chk(name, {15'h0000, e}, {15'h0000, g});
  endtask

  // Low byte first so the high read sees the holding byte when needed
  task automatic rd16(input logic [ADDR_W-1:0] lo, output logic [15:0] val);
    logic [7:0] b;
    i_cpu.rd(lo, b);
    val[7:0] = b;
    i_cpu.rd(lo + 4'h1, b);
    val[15:8] = b;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog, well above the several hundred cycles the sequence needs
  initial begin
    #500000;
    n_fail++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    cap_ev = 1'b0;
    seed = 32'd52009;
    acts = '{ACT_SET, ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_TOGGLE};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chkb("out_a reset", 1'b0, out_a);
    chkb("out_b reset", 1'b0, out_b);
    // Every register reads zero after reset, unmapped writes are dropped
    i_cpu.wr(4'hD, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      i_cpu.rd(i[3:0], d);
      chk("reset read", 16'h0000, {8'h00, d});
    end
    // Direct compare access in normal mode, high byte read bypasses holding
    r = xs();
    v = r[15:0];
    i_cpu.wr16(REG_CMPA_LOW, v);
    rd16(REG_CMPA_LOW, got);
    chk("cmp_a", v, got);
    i_cpu.wr(REG_CMPB_HIGH, ~v[15:8]);
    i_cpu.rd(REG_CMPA_HIGH, d);
    chk("cmp_a high", {8'h00, v[15:8]}, {8'h00, d});
    // Two captures with no read between: the later one wins
    for (int i = 0; i < 2; i++) begin
      r = xs();
      cap_q.push_back(int'(r[15:0]));
      i_cpu.wr16(REG_COUNT_LOW, r[15:0]);
      @(posedge clk);
      cap_ev <= 1'b1;
      @(posedge clk);
      cap_ev <= 1'b0;
    end
    rd16(REG_CAPT_LOW, got);
    chk("capture", cap_q[$][15:0], got);
    i_cpu.rd(REG_FLAGS, d);
    chkb("capt flag", 1'b1, d[FLAG_CAPT_POS]);
    i_cpu.wr(REG_IRQ_EN, 8'h20);
    #1;
    chkb("irq_capt", 1'b1, irq_c);
    i_cpu.wr(REG_FLAGS, 8'h20);
    #1;
    chkb("irq_capt clr", 1'b0, irq_c);
    i_cpu.rd(REG_FLAGS, d);
    chkb("capt flag clr", 1'b0, d[FLAG_CAPT_POS]);
    // preset output with force, walking every action code
    exp_out = 1'b0;
    for (int i = 0; i < 5; i++) begin
      i_cpu.wr(REG_CTRL_A, {acts[i], 6'h00});
      #1;
      chkb("out_en_a", acts[i] != ACT_NONE, en_a);
      chkb("out_en_b", 1'b0, en_b);
      i_cpu.wr(REG_FORCE, 8'h80);
      #1;
      case (acts[i])
        ACT_SET: exp_out = 1'b1;
        ACT_CLEAR: exp_out = 1'b0;
        ACT_TOGGLE: exp_out = ~exp_out;
        default: exp_out = exp_out;
      endcase
      chkb("force out_a", exp_out, out_a);
    end
    i_cpu.rd(REG_FLAGS, d);
    chkb("force no flag", 1'b0, d[FLAG_A_POS]);
    // Switch to clear-on-compare-A mode; output state must survive
    i_cpu.wr(REG_CTRL_B, 8'h08);
    #1;
    chkb("out_a kept", exp_out, out_a);
    // Channel A toggles and sets the top; count written to zero blocks first tick
    i_cpu.wr(REG_CTRL_A, 8'h40);
    i_cpu.wr(REG_IRQ_EN, 8'h06);
    i_cpu.wr(REG_FLAGS, 8'h26);
    r = xs();
    k = 16'h0008 + {11'h000, r[4:0]};
    i_cpu.wr16(REG_CMPA_LOW, k);
    i_cpu.wr16(REG_CMPB_LOW, 16'h0000);
    i_cpu.wr16(REG_COUNT_LOW, 16'h0000);
    i_cpu.wr(REG_CTRL_B, 8'h09);
    repeat (k) @(posedge clk);
    #1;
    chkb("irq_a early", 1'b0, irq_a);
    chkb("irq_b blocked", 1'b0, irq_b);
    @(posedge clk);
    #1;
    chkb("irq_a match", 1'b1, irq_a);
    chkb("out_a toggled", ~exp_out, out_a);
    i_cpu.ack_pulse(0);
    #1;
    chkb("irq_a acked", 1'b0, irq_a);
    repeat (k - 16'h0002) @(posedge clk);
    #1;
    chkb("irq_a period", 1'b0, irq_a);
    @(posedge clk);
    #1;
    chkb("irq_a top", 1'b1, irq_a);
    chkb("out_a back", exp_out, out_a);
    i_cpu.wr(REG_CTRL_B, 8'h08);
    i_cpu.wr(REG_FLAGS, 8'h00);
    #1;
    chkb("flag kept", 1'b1, irq_a);
    i_cpu.wr(REG_FLAGS, 8'h02);
    #1;
    chkb("flag cleared", 1'b0, irq_a);
    // Fast PWM with top FF: channel B value waits in the buffer until top
    i_cpu.wr16(REG_CMPB_LOW, 16'h0005);
    i_cpu.wr16(REG_COUNT_LOW, 16'h0010);
    i_cpu.wr(REG_CTRL_A, 8'h01);
    i_cpu.wr(REG_FLAGS, 8'h26);
    i_cpu.wr(REG_FORCE, 8'h80);
    #1;
    chkb("pwm force ignored", exp_out, out_a);
    r = xs();
    v = 16'h0040 + {9'h000, r[6:0]};
    i_cpu.wr16(REG_CMPB_LOW, v);
    rd16(REG_CMPB_LOW, got);
    chk("cmp_b buffer", v, got);
    i_cpu.wr(REG_CTRL_B, 8'h09);
    repeat (200) @(posedge clk);
    #1;
    chkb("irq_b held", 1'b0, irq_b);
    for (int i = 0; i < 400 && irq_b !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chkb("irq_b after top", 1'b1, irq_b);
    test_done();
  end
endmodule
`default_nettype wire
